//--- src/charger_detect_cfg.svh
// offsets, field positions, reset values and timing counts for charger detect
`ifndef CHARGER_DETECT_CFG_SVH
`define CHARGER_DETECT_CFG_SVH
`define CD_ADDR_CTRL      12'h000
`define CD_ADDR_STATUS    12'h004
`define CD_ADDR_MASK      12'h008
`define CD_ADDR_IRQ_STAT  12'h00c
`define CD_ADDR_IRQ_MASK  12'h010
`define CD_ADDR_CUSTOM    12'h014
`define CD_CTRL_RESET     32'h0000_0003
`define CD_MASK_RESET     8'h7e
`define CD_CTRL_DET_EN    0
`define CD_CTRL_ENHANCED  1
`define CD_CTRL_OSC_EN    2
`define CD_CTRL_EVT_MODE  3
`define CD_CTRL_BIT0_EN   4
`define CD_CTRL_BIT1_EN   5
`define CD_CTRL_DS_EN_LO  8
`define CD_CTRL_SUPPLY    12
`define CD_IRQ_STATUS     0
`define CD_IRQ_CLASSIFY   1
`define CD_IRQ_W          2
`define CD_SETTLE_NS      1000
`define CD_CLK_NS         5
`define CD_SETTLE_CYC     ((`CD_SETTLE_NS + `CD_CLK_NS - 1) / `CD_CLK_NS)
`define CD_CNT_W          8
`endif

//--- src/charger_detect_pkg.sv
// types shared by the charger detection block
package charger_detect_pkg;
    typedef enum logic [2:0] {
        chg_none  = 3'b000,
        chg_dcp   = 3'b001,
        chg_cdp   = 3'b010,
        chg_sdp   = 3'b011,
        chg_vlow  = 3'b100,
        chg_vhigh = 3'b101,
        chg_vsup  = 3'b110
    } charger_type_e;

    typedef enum logic [1:0] {
        out_idle       = 2'b00,
        out_vbus       = 2'b01,
        out_configured = 2'b10,
        out_charger    = 2'b11
    } detect_code_e;

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_settle = 3'b001,
        st_sample = 3'b010,
        st_done   = 3'b011,
        st_custom = 3'b100
    } detect_state_e;

    typedef enum logic [2:0] {
        stage_other    = 3'b000,
        stage_waitref  = 3'b001,
        stage_config   = 3'b010,
        stage_connect  = 3'b011,
        stage_chgdet   = 3'b100
    } hub_stage_e;

    // sensed upstream line classes from the analog comparators
    typedef struct packed {
        logic dp_dm_short;
        logic dm_reflects_dp;
        logic pulldowns;
        logic dp_high;
        logic dm_high;
        logic dp_mid;
        logic dm_mid;
    } line_sense_s;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
endpackage

//--- src/usb_charger_detect_status.sv
// upstream charger detection, detect pins, status registers over apb
// Operation
// - detection starts on charger-detect stage when enabled
// - charger type reported as 3-bit code
// - cdp code only with enhanced detect
// - recognised line range updates pins and status
// - custom detection allowed, but a sample in the same cycle overrides the custom type
// - mask selects which types drive detect pins
// - optional detection from oscillator while awaiting refclock
// - no detection in inter-chip upstream mode
// - pins show charger type or device event
// - each detect pin bit separately enabled
// - pins follow internal two-bit status field
// - two-bit encodings 00 01 10 11
// - interrupt once charger status is ready
// - charging ports acknowledge battery charging query
// - one supply indication for all downstream ports
// - no downstream charging on inter-chip ports
// - smbus slave enabled only with both lines high
// - smbus slave reaches registers and otp
`timescale 1ns/10ps
`include "charger_detect_cfg.svh"

module usb_charger_detect_status
    import charger_detect_pkg::*;
#(
    parameter int DS_PORTS = 3
) (
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [11:0]         paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    input  wire logic [2:0]          hub_stage_in,
    input  wire logic                hub_mode_in,
    input  wire logic                upstream_hsic_in,
    input  wire logic                reference_clock_ok_in,
    input  wire logic [6:0]          line_sense_in,
    input  wire logic                vbus_seen_in,
    input  wire logic                configured_in,
    input  wire logic                suspended_in,
    input  wire logic [DS_PORTS-1:0] ds_hsic_in,
    input  wire logic [DS_PORTS-1:0] ds_query_in,
    input  wire logic                smbus_clk_line_in,
    input  wire logic                smbus_data_line_in,
    output logic      [1:0]          charger_detect_out,
    output logic                     charge_supply_indicate_out,
    output logic      [DS_PORTS-1:0] ds_charge_ack_out,
    output logic                     smbus_enable_out,
    output logic                     otp_access_out,
    output logic                     irq_out
);
    localparam logic [`CD_CNT_W-1:0] SETTLE_CYC =
        `CD_CNT_W'(`CD_SETTLE_CYC);

    apb_req_s      req;
    line_sense_s   sense;
    hub_stage_e    stage;
    detect_state_e state_ff;
    detect_state_e nxt_state;
    charger_type_e type_ff;
    charger_type_e nxt_type;
    logic [31:0]   ctrl_ff;
    logic [7:0]    mask_ff;
    logic [`CD_IRQ_W-1:0] irq_stat_ff;
    logic [`CD_IRQ_W-1:0] irq_mask_ff;
    logic [2:0]    custom_ff;
    logic [1:0]    status_field_ff;
    logic [1:0]    nxt_field;
    logic [`CD_CNT_W-1:0] cnt_ff;
    logic          done_ff;
    logic          wr;
    logic          setup;
    logic          start;
    logic          clock_ok;
    logic          classify_evt;
    logic          field_evt;
    logic [31:0]   rdata;
    logic          addr_ok;
    logic          wr_custom;
    logic          path_ok;
    logic          stage_ok;
    logic          smbus_pullups;
    logic [1:0]    pin_en;
    logic [`CD_IRQ_W-1:0] irq_set;
    logic [`CD_IRQ_W-1:0] irq_clr;
    logic [`CD_IRQ_W-1:0] nxt_irq_stat;

    assign req   = '{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in};
    assign sense = line_sense_s'(line_sense_in);
    assign stage = hub_stage_e'(hub_stage_in);
    assign wr    = req.psel && req.penable && req.pwrite;
    assign setup     = req.psel && !req.penable;
    assign wr_custom = wr && req.paddr == `CD_ADDR_CUSTOM;
    assign pin_en    = {ctrl_ff[`CD_CTRL_BIT1_EN],
                        ctrl_ff[`CD_CTRL_BIT0_EN]};

    // oscillator fallback lets a dead-battery system still classify
    assign clock_ok = reference_clock_ok_in ||
        (ctrl_ff[`CD_CTRL_OSC_EN] && stage == stage_waitref);
    // no upstream charger detection over the inter-chip link
    assign path_ok  = hub_mode_in && !upstream_hsic_in;
    assign stage_ok = stage == stage_chgdet || stage == stage_waitref;
    assign start    = ctrl_ff[`CD_CTRL_DET_EN] && path_ok && stage_ok &&
        clock_ok && state_ff == st_idle;

    // classification of the sampled upstream line state
    always_comb begin
        nxt_type = chg_none;
        if (sense.dp_high && sense.dm_mid) begin
            nxt_type = chg_vsup;
        end else if (sense.dp_mid && sense.dm_high) begin
            nxt_type = chg_vhigh;
        end else if (sense.dp_mid && sense.dm_mid) begin
            nxt_type = chg_vlow;
        end else if (sense.dp_dm_short) begin
            nxt_type = chg_dcp;
        end else if (sense.dm_reflects_dp) begin
            // without enhanced mode a reflecting port reads as sdp
            nxt_type = ctrl_ff[`CD_CTRL_ENHANCED] ? chg_cdp : chg_sdp;
        end else if (sense.pulldowns) begin
            nxt_type = chg_sdp;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_idle: begin
                if (start) begin
                    nxt_state = st_settle;
                end
            end
            st_settle: begin
                if (upstream_hsic_in) begin
                    nxt_state = st_idle;
                end else if (cnt_ff == SETTLE_CYC) begin
                    nxt_state = st_sample;
                end
            end
            st_sample: begin
                nxt_state = st_done;
            end
            st_done: begin
                if (!ctrl_ff[`CD_CTRL_DET_EN]) begin
                    nxt_state = st_idle;
                end
            end
            st_custom: begin
                nxt_state = st_custom;
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= st_idle;
        end else if (wr_custom) begin
            // software takes the block over; stage is its own concern
            state_ff <= detect_state_e'(st_custom);
        end else if (state_ff == st_custom &&
                     !ctrl_ff[`CD_CTRL_DET_EN]) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= '0;
        end else if (state_ff == st_settle) begin
            cnt_ff <= cnt_ff + `CD_CNT_W'(1);
        end else begin
            cnt_ff <= '0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            type_ff <= chg_none;
        end else if (state_ff == st_sample) begin
            type_ff <= nxt_type;
        end else if (wr_custom) begin
            type_ff <= charger_type_e'(req.pwdata[2:0]);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff <= 1'b0;
        end else if (state_ff == st_sample || wr_custom) begin
            done_ff <= 1'b1;
        end else if (state_ff == st_idle && start) begin
            done_ff <= 1'b0;
        end
    end
    assign classify_evt = state_ff == st_sample;

    // detect field: charger type via mask, or device event
    always_comb begin
        nxt_field = out_idle;
        // event mode ignores the detected type entirely
        if (ctrl_ff[`CD_CTRL_EVT_MODE]) begin
            if (configured_in) begin
                nxt_field = out_configured;
            end else if (vbus_seen_in && !suspended_in) begin
                nxt_field = out_vbus;
            end
        end else if (done_ff && mask_ff[type_ff]) begin
            nxt_field = out_charger;
        end
        nxt_field = nxt_field & pin_en;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_field_ff <= out_idle;
        end else begin
            status_field_ff <= nxt_field;
        end
    end

    // pins get their own flop so they are a bare register output
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            charger_detect_out <= out_idle;
        end else begin
            charger_detect_out <= nxt_field;
        end
    end
    assign field_evt = nxt_field != status_field_ff;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_ff     <= `CD_CTRL_RESET;
            mask_ff     <= `CD_MASK_RESET;
            irq_mask_ff <= '0;
            custom_ff   <= '0;
        end else if (wr) begin
            unique case (req.paddr)
                `CD_ADDR_CTRL: begin
                    ctrl_ff <= req.pwdata;
                end
                `CD_ADDR_MASK: begin
                    mask_ff <= req.pwdata[7:0];
                end
                `CD_ADDR_IRQ_MASK: begin
                    irq_mask_ff <= req.pwdata[`CD_IRQ_W-1:0];
                end
                `CD_ADDR_CUSTOM: begin
                    custom_ff <= req.pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        irq_set = '0;
        irq_clr = '0;
        irq_set[`CD_IRQ_STATUS]   = field_evt;
        irq_set[`CD_IRQ_CLASSIFY] = classify_evt;
        if (wr && req.paddr == `CD_ADDR_IRQ_STAT) begin
            irq_clr = req.pwdata[`CD_IRQ_W-1:0];
        end
        // set wins over write-one-to-clear in the same cycle
        nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    genvar p;
    generate
        for (p = 0; p < DS_PORTS; p++) begin : g_port
            always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ds_charge_ack_out[p] <= 1'b0;
                end else begin
                    ds_charge_ack_out[p] <= ds_query_in[p] &&
                        ctrl_ff[`CD_CTRL_DS_EN_LO + p] &&
                        !ds_hsic_in[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            charge_supply_indicate_out <= 1'b0;
        end else begin
            charge_supply_indicate_out <= ctrl_ff[`CD_CTRL_SUPPLY];
        end
    end

    // a low data line alone is enough to keep the slave off
    assign smbus_pullups = smbus_clk_line_in && smbus_data_line_in;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smbus_enable_out <= 1'b0;
            otp_access_out   <= 1'b0;
        end else begin
            smbus_enable_out <= smbus_pullups;
            otp_access_out   <= smbus_pullups;
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        rdata   = '0;
        unique case (req.paddr)
            `CD_ADDR_CTRL: begin
                rdata = ctrl_ff;
            end
            `CD_ADDR_STATUS: begin
                rdata = {23'h0, state_ff, status_field_ff,
                         done_ff, type_ff[2:0]};
            end
            `CD_ADDR_MASK: begin
                rdata = {24'h0, mask_ff};
            end
            `CD_ADDR_IRQ_STAT: begin
                rdata = {30'h0, irq_stat_ff};
            end
            `CD_ADDR_IRQ_MASK: begin
                rdata = {30'h0, irq_mask_ff};
            end
            `CD_ADDR_CUSTOM: begin
                rdata = {29'h0, custom_ff};
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out  <= '0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && !addr_ok;
            if (setup && !req.pwrite) begin
                prdata_out <= rdata;
            end
        end
    end
endmodule

//--- testbench/charger_model.sv
// upstream charger stand-in: sensed line classes for each charger kind
`timescale 1ns/10ps
module charger_model (
    input  wire logic [2:0] kind_in,
    output logic      [6:0] line_sense_out
);
    // bit order: short, reflect, pulldowns, dp/dm high, dp/dm mid
    always_comb begin
        case (kind_in)
            3'h1:    line_sense_out = 7'h40;
            3'h2:    line_sense_out = 7'h20;
            3'h3:    line_sense_out = 7'h10;
            3'h4:    line_sense_out = 7'h03;
            3'h5:    line_sense_out = 7'h06;
            3'h6:    line_sense_out = 7'h09;
            default: line_sense_out = 7'h00;
        endcase
    end
endmodule

//--- testbench/cd_checker_properties.sv
// port-level assertions for the charger detection block
`timescale 1ns/10ps
module cd_checker
    import charger_detect_pkg::*;
#(
    parameter int DS_PORTS = 3
) (
    input wire logic                sys_clk_in,
    input wire logic                rst_n_in,
    input wire logic                psel_in,
    input wire logic                penable_in,
    input wire logic                pwrite_in,
    input wire logic [11:0]         paddr_in,
    input wire logic [31:0]         pwdata_in,
    input wire logic [31:0]         prdata_out,
    input wire logic                pready_out,
    input wire logic                pslverr_out,
    input wire logic [2:0]          hub_stage_in,
    input wire logic                hub_mode_in,
    input wire logic                upstream_hsic_in,
    input wire logic                reference_clock_ok_in,
    input wire logic [6:0]          line_sense_in,
    input wire logic                vbus_seen_in,
    input wire logic                configured_in,
    input wire logic                suspended_in,
    input wire logic [DS_PORTS-1:0] ds_hsic_in,
    input wire logic [DS_PORTS-1:0] ds_query_in,
    input wire logic                smbus_clk_line_in,
    input wire logic                smbus_data_line_in,
    input wire logic [1:0]          charger_detect_out,
    input wire logic                charge_supply_indicate_out,
    input wire logic [DS_PORTS-1:0] ds_charge_ack_out,
    input wire logic                smbus_enable_out,
    input wire logic                otp_access_out,
    input wire logic                irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence apb_setup;
        psel_in && !penable_in;
    endsequence
    sequence apb_access;
        psel_in && penable_in;
    endsequence
    AST_READY_AFTER_SETUP: assert property (apb_setup ##1 apb_access |-> pready_out)
        else $error("pready missing in access cycle");
    AST_READY_ONLY_ACCESS: assert property (pready_out |-> apb_access)
        else $error("pready outside access cycle");
    AST_ERR_UNMAPPED: assert property (
        apb_setup and (paddr_in > 12'h014) |=> pready_out && pslverr_out)
        else $error("unmapped access not refused");
    AST_SMB_ON: assert property (
        (smbus_clk_line_in && smbus_data_line_in) [*2] |-> smbus_enable_out)
        else $error("smbus slave not enabled");
    AST_SMB_OFF: assert property (
        !smbus_data_line_in |=> !smbus_enable_out && !otp_access_out)
        else $error("smbus slave enabled with data line low");
    AST_OTP_PATH: assert property (otp_access_out == smbus_enable_out)
        else $error("otp path differs from smbus enable");
    AST_DS_HSIC: assert property (
        1'b1 |=> (ds_charge_ack_out & $past(ds_hsic_in)) == '0)
        else $error("charge ack on inter-chip port");
    AST_DS_QUERY: assert property (
        1'b1 |=> (ds_charge_ack_out & ~$past(ds_query_in)) == '0)
        else $error("charge ack without query");
    AST_RESET_PINS: assert property (
        $rose(rst_n_in) |-> charger_detect_out == 2'b00 && !irq_out)
        else $error("outputs not idle after reset");
endmodule
bind usb_charger_detect_status cd_checker #(.DS_PORTS(DS_PORTS)) u_chk (.*);

//--- testbench/tb_usb_charger_detect_status.sv
// self-checking bench for the charger detection block
`timescale 1ns/10ps
`include "charger_detect_cfg.svh"
module tb_usb_charger_detect_status;
    logic sys_clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic pready_out, pslverr_out, hub_mode_in, upstream_hsic_in;
    logic [2:0] hub_stage_in, ds_hsic_in, ds_query_in, ds_charge_ack_out;
    logic reference_clock_ok_in, vbus_seen_in, configured_in, suspended_in;
    logic [6:0] line_sense_in;
    logic smbus_clk_line_in, smbus_data_line_in, charge_supply_indicate_out;
    logic [1:0] charger_detect_out;
    logic smbus_enable_out, otp_access_out, irq_out;
    logic [2:0] kind;
    logic [31:0] r, rnd;
    logic e;
    logic [7:0] mask;
    int error_cnt, cmp_count, seed, t;

    usb_charger_detect_status dut (.*);
    charger_model u_chg (.kind_in(kind), .line_sense_out(line_sense_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check_val(input string nm, input logic [31:0] x, g);
        cmp_count++;
        if (g !== x) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        r = prdata_out;
        e = pslverr_out;
        if (n >= 16) error_cnt++;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] x, m);
        apb(1'b0, a, 32'h0);
        check_val(nm, x & m, r & m);
    endtask

    // detection restarts only from idle, so drop the enable first
    task automatic detect(input int prof, input logic [31:0] ctrl);
        kind <= prof[2:0];
        apb(1'b1, `CD_ADDR_CTRL, ctrl);
        apb(1'b1, `CD_ADDR_CTRL, ctrl | 32'h1);
        repeat (210) @(posedge sys_clk_in);
    endtask

    task automatic run_irq(input logic [31:0] ctrl, input logic x);
        apb(1'b1, `CD_ADDR_IRQ_STAT, 32'h3);
        detect(1, ctrl);
        rd_chk("classified", `CD_ADDR_IRQ_STAT, {30'h0, x, 1'b0}, 32'h2);
    endtask

    function automatic int model_type(int p, logic enh);
        int tab[7] = '{0, 1, 3, 3, 4, 5, 6};
        return (p == 2 && enh) ? 2 : tab[p];
    endfunction

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        seed = 32'h084be6e2;
        {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {hub_stage_in, hub_mode_in, upstream_hsic_in, kind} = '0;
        {reference_clock_ok_in, vbus_seen_in, configured_in} = '0;
        {suspended_in, ds_hsic_in, ds_query_in} = '0;
        {smbus_clk_line_in, smbus_data_line_in} = '0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd_chk("ctrl", `CD_ADDR_CTRL, 32'h3, '1);
        rd_chk("mask", `CD_ADDR_MASK, 32'h7e, '1);
        rd_chk("irq mask", `CD_ADDR_IRQ_MASK, 32'h0, '1);
        rd_chk("status", `CD_ADDR_STATUS, 32'h0, 32'h3f);
        check_val("pins", 32'h0, {30'h0, charger_detect_out});
        apb(1'b0, 12'h018, 32'h0);
        check_val("unmapped", 32'h1, {r[30:0], e});
        $display("test reset done");
        hub_mode_in <= 1'b1;
        hub_stage_in <= 3'b100;
        reference_clock_ok_in <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            rnd = $random(seed);
            mask = rnd[7:0] & 8'hfe;
            apb(1'b1, `CD_ADDR_MASK, {24'h0, mask});
            detect(p % 7 + p / 7 * 2, {30'hc, p == 7, 1'b0});
            t = model_type(p % 7 + p / 7 * 2, p == 7);
            rd_chk("type", `CD_ADDR_STATUS, t | 8 | mask[t] * 48, 32'h3f);
            check_val("pins", mask[t] * 3, {30'h0, charger_detect_out});
        end
        apb(1'b1, `CD_ADDR_MASK, 32'h2);
        for (int b = 1; b < 3; b++) begin
            detect(1, 32'h8 << b);
            check_val("pin bit", b, {30'h0, charger_detect_out});
        end
        $display("test detection done");
        rd_chk("irq off", `CD_ADDR_IRQ_STAT, 32'h2, 32'h2);
        check_val("irq masked", 32'h0, {31'h0, irq_out});
        apb(1'b1, `CD_ADDR_IRQ_MASK, 32'h2);
        repeat (2) @(posedge sys_clk_in);
        check_val("irq", 32'h1, {31'h0, irq_out});
        apb(1'b1, `CD_ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge sys_clk_in);
        check_val("irq cleared", 32'h0, {31'h0, irq_out});
        upstream_hsic_in <= 1'b1;
        run_irq(32'h30, 1'b0);
        upstream_hsic_in <= 1'b0;
        hub_stage_in <= 3'b000;
        run_irq(32'h30, 1'b0);
        hub_stage_in <= 3'b001;
        reference_clock_ok_in <= 1'b0;
        run_irq(32'h30, 1'b0);
        run_irq(32'h34, 1'b1);
        fork
            run_irq(32'h34, 1'b0);
            begin
                repeat (100) @(posedge sys_clk_in);
                upstream_hsic_in <= 1'b1;
            end
        join
        upstream_hsic_in <= 1'b0;
        $display("test stages done");
        apb(1'b1, `CD_ADDR_CTRL, 32'h38);
        for (int v = 0; v < 4; v++) begin
            {configured_in, vbus_seen_in, suspended_in} <= 3'h4 >> v;
            repeat (4) @(posedge sys_clk_in);
            check_val("event pins", 32'h2 >> v, {30'h0, charger_detect_out});
        end
        hub_stage_in <= 3'b010;
        apb(1'b1, `CD_ADDR_CUSTOM, 32'h5);
        rd_chk("custom", `CD_ADDR_STATUS, 32'hd, 32'hf);
        rst_n_in <= 1'b0;
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        check_val("pins reset", 32'h0, {30'h0, charger_detect_out});
        rd_chk("type reset", `CD_ADDR_STATUS, 32'h0, 32'h3f);
        $display("test reset again done");
        for (int k = 0; k < 8; k++) begin
            rnd = $random(seed);
            apb(1'b1, `CD_ADDR_CTRL, rnd & 32'h1700);
            {ds_query_in, ds_hsic_in} <= rnd[5:0];
            {smbus_clk_line_in, smbus_data_line_in} <= rnd[7:6];
            repeat (3) @(posedge sys_clk_in);
            check_val("ack", rnd[10:8] & rnd[5:3] & ~rnd[2:0], ds_charge_ack_out);
            check_val("supply", rnd[12], charge_supply_indicate_out);
            check_val("smbus", {2{&rnd[7:6]}}, {smbus_enable_out, otp_access_out});
        end
        $display("test ports done");
        give_verdict();
    end
endmodule
